// ==== hdl/pdma_channel.v ====
`include "pdma_regs.vh"

module pdma_channel (
   // Clock and reset
   input wire clk_sys,
   input wire rstn,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output reg [31:0] hrdata,
   // Peripheral side
   input wire half_duplex,
   input wire [1:0] xfer_size,
   input wire rx_ready,
   input wire [31:0] rx_data,
   output wire rx_take,
   input wire tx_ready,
   output reg [31:0] tx_data,
   output reg tx_load,
   // Status toward the peripheral
   output reg rx_end_flag,
   output reg rx_buffers_full_flag,
   output reg tx_end_flag,
   output reg tx_buffers_empty_flag,
   // Memory master
   output reg mem_req,
   output reg mem_we,
   output reg [31:0] mem_addr,
   output reg [1:0] mem_size,
   output reg [31:0] mem_wdata,
   input wire mem_ack,
   input wire [31:0] mem_rdata
);

   localparam ST_IDLE = 2'h0;
   localparam ST_RX_WR = 2'h1;
   localparam ST_TX_RD = 2'h2;

   function [31:0] step_incr;
      input [1:0] sz;
      begin
         case (sz)
            `PDMA_SZ_BYTE: step_incr = `PDMA_INC_BYTE;
            `PDMA_SZ_HALF: step_incr = `PDMA_INC_HALF;
            default: step_incr = `PDMA_INC_WORD;
         endcase
      end
   endfunction

   // Channel slot used by a direction; half duplex folds both onto 0
   function chan_idx;
      input is_tx;
      input hd;
      begin
         chan_idx = is_tx & ~hd;
      end
   endfunction

   reg [31:0] cur_addr_q [0:1];
   reg [15:0] cur_cnt_q [0:1];
   reg [31:0] nxt_addr_q [0:1];
   reg [15:0] nxt_cnt_q [0:1];
   reg rx_en_q;
   reg tx_en_q;
   reg [1:0] state_q;
   reg step_q;
   reg [1:0] step_sz_q;
   reg wr_pend_q;
   reg rd_pend_q;
   reg [11:0] bus_addr_q;
   reg [31:0] rd_mux;
   reg step_go;
   reg step_ch;
   integer k;

   wire rxi = chan_idx(1'b0, half_duplex);
   wire txi = chan_idx(1'b1, half_duplex);
   wire addr_ph = hsel & htrans[1] & hready;
   wire wr_ctrl = wr_pend_q & (bus_addr_q == `PDMA_A_CTRL);
   wire c_rx_en = hwdata[`PDMA_RX_EN_BIT];
   wire c_rx_dis = hwdata[`PDMA_RX_DIS_BIT];
   wire c_tx_en = hwdata[`PDMA_TX_EN_BIT];
   wire c_tx_dis = hwdata[`PDMA_TX_DIS_BIT];
   wire rx_cnt_nz = cur_cnt_q[rxi] != `PDMA_RST_CNT;
   wire tx_cnt_nz = cur_cnt_q[txi] != `PDMA_RST_CNT;
   // Count and enable gate
   // No start while a step is pending: count and pointer are still stale
   wire rx_start = rx_en_q & rx_ready & rx_cnt_nz & ~step_q;
   wire tx_start = tx_en_q & tx_ready & tx_cnt_nz & ~rx_start & ~step_q;

   assign hreadyout = ~rd_pend_q;
   assign hresp = 1'b0;
   // Receive gets priority so the holding register does not overrun
   assign rx_take = (state_q == ST_IDLE) & rx_start;

   // Bus phases: writes need no wait, reads take one wait state
   always @(posedge clk_sys) begin
      if (!rstn) begin
         wr_pend_q <= 1'b0;
         rd_pend_q <= 1'b0;
         bus_addr_q <= 12'h000;
      end else begin
         wr_pend_q <= addr_ph & hwrite;
         rd_pend_q <= addr_ph & ~hwrite;
         if (addr_ph)
            bus_addr_q <= haddr[11:0];
      end
   end

   always @* begin
      rd_mux = 32'h0000_0000;
      case (bus_addr_q)
         `PDMA_A_RX_CUR_ADDR: rd_mux = cur_addr_q[rxi];
         `PDMA_A_RX_CUR_CNT: rd_mux = {16'h0000, cur_cnt_q[rxi]};
         `PDMA_A_TX_CUR_ADDR: rd_mux = cur_addr_q[txi];
         `PDMA_A_TX_CUR_CNT: rd_mux = {16'h0000, cur_cnt_q[txi]};
         `PDMA_A_RX_NXT_ADDR: rd_mux = nxt_addr_q[rxi];
         `PDMA_A_RX_NXT_CNT: rd_mux = {16'h0000, nxt_cnt_q[rxi]};
         `PDMA_A_TX_NXT_ADDR: rd_mux = nxt_addr_q[txi];
         `PDMA_A_TX_NXT_CNT: rd_mux = {16'h0000, nxt_cnt_q[txi]};
         `PDMA_A_STAT: begin
            rd_mux[`PDMA_RX_EN_BIT] = rx_en_q;
            rd_mux[`PDMA_TX_EN_BIT] = tx_en_q;
         end
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!rstn)
         hrdata <= 32'h0000_0000;
      else if (rd_pend_q)
         hrdata <= rd_mux;
   end

   // Enable state from control writes
   always @(posedge clk_sys) begin
      if (!rstn) begin
         rx_en_q <= 1'b0;
         tx_en_q <= 1'b0;
      end else if (wr_ctrl) begin
         if (c_rx_dis)
            rx_en_q <= 1'b0;
         else if (half_duplex & c_tx_dis)
            rx_en_q <= 1'b0;
         else if (c_rx_en)
            rx_en_q <= 1'b1;
         if (c_tx_dis)
            tx_en_q <= 1'b0;
         // Half duplex: receive enable or disable drops transmit
         else if (half_duplex & (c_rx_en | c_rx_dis))
            tx_en_q <= 1'b0;
         // Transmit enable blocked in half duplex by receive enable or disable
         else if (c_tx_en)
            tx_en_q <= 1'b1;
      end
   end

   // Transfer sequencer
   always @(posedge clk_sys) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         mem_req <= 1'b0;
         mem_we <= 1'b0;
         mem_addr <= `PDMA_RST_ADDR;
         mem_size <= `PDMA_SZ_BYTE;
         mem_wdata <= 32'h0000_0000;
         tx_data <= 32'h0000_0000;
         tx_load <= 1'b0;
         step_q <= 1'b0;
         step_sz_q <= `PDMA_SZ_BYTE;
      end else begin
         tx_load <= 1'b0;
         step_q <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (rx_start) begin
                  state_q <= ST_RX_WR;
                  mem_req <= 1'b1;
                  mem_we <= 1'b1;
                  mem_addr <= cur_addr_q[rxi];
                  mem_size <= xfer_size;
                  mem_wdata <= rx_data;
               end else if (tx_start) begin
                  // Pointer taken as loaded by software
                  state_q <= ST_TX_RD;
                  mem_req <= 1'b1;
                  mem_we <= 1'b0;
                  mem_addr <= cur_addr_q[txi];
                  mem_size <= xfer_size;
               end
            end
            ST_RX_WR: begin
               if (mem_ack) begin
                  state_q <= ST_IDLE;
                  mem_req <= 1'b0;
                  mem_we <= 1'b0;
                  step_q <= 1'b1;
                  step_sz_q <= mem_size;
               end
            end
            ST_TX_RD: begin
               if (mem_ack) begin
                  state_q <= ST_IDLE;
                  mem_req <= 1'b0;
                  tx_data <= mem_rdata;
                  tx_load <= 1'b1;
                  step_q <= 1'b1;
                  step_sz_q <= mem_size;
               end
            end
            default: begin
               state_q <= ST_IDLE;
               mem_req <= 1'b0;
            end
         endcase
      end
   end

   // Direction of the step that just finished
   reg step_tx_q;
   always @(posedge clk_sys) begin
      if (!rstn)
         step_tx_q <= 1'b0;
      else if (state_q == ST_IDLE)
         step_tx_q <= ~rx_start;
   end

   always @* begin
      step_go = step_q;
      step_ch = chan_idx(step_tx_q, half_duplex);
   end

   // Pointers and counters; software writes win over hardware updates
   always @(posedge clk_sys) begin
      if (!rstn) begin
         for (k = 0; k < 2; k = k + 1) begin
            cur_addr_q[k] <= `PDMA_RST_ADDR;
            cur_cnt_q[k] <= `PDMA_RST_CNT;
            nxt_addr_q[k] <= `PDMA_RST_ADDR;
            nxt_cnt_q[k] <= `PDMA_RST_CNT;
         end
      end else begin
         for (k = 0; k < 2; k = k + 1) begin
            // Reload from next buffer, else stop
            if (cur_cnt_q[k] == `PDMA_RST_CNT &&
                nxt_cnt_q[k] != `PDMA_RST_CNT) begin
               cur_addr_q[k] <= nxt_addr_q[k];
               cur_cnt_q[k] <= nxt_cnt_q[k];
               nxt_addr_q[k] <= `PDMA_RST_ADDR;
               nxt_cnt_q[k] <= `PDMA_RST_CNT;
            end
         end
         if (step_go) begin
            cur_addr_q[step_ch] <= cur_addr_q[step_ch] +
                                   step_incr(step_sz_q);
            cur_cnt_q[step_ch] <= cur_cnt_q[step_ch] - 16'h0001;
         end
         if (wr_pend_q) begin
            // Shared slots via rxi and txi
            case (bus_addr_q)
               `PDMA_A_RX_CUR_ADDR: cur_addr_q[rxi] <= hwdata;
               `PDMA_A_RX_CUR_CNT:
                  cur_cnt_q[rxi] <= hwdata[`PDMA_CNT_W-1:0];
               `PDMA_A_TX_CUR_ADDR: cur_addr_q[txi] <= hwdata;
               `PDMA_A_TX_CUR_CNT:
                  cur_cnt_q[txi] <= hwdata[`PDMA_CNT_W-1:0];
               `PDMA_A_RX_NXT_ADDR: nxt_addr_q[rxi] <= hwdata;
               `PDMA_A_RX_NXT_CNT:
                  nxt_cnt_q[rxi] <= hwdata[`PDMA_CNT_W-1:0];
               `PDMA_A_TX_NXT_ADDR: nxt_addr_q[txi] <= hwdata;
               `PDMA_A_TX_NXT_CNT:
                  nxt_cnt_q[txi] <= hwdata[`PDMA_CNT_W-1:0];
               default: ;
            endcase
         end
      end
   end

   // Status flags follow the counters one cycle later
   always @(posedge clk_sys) begin
      if (!rstn) begin
         rx_end_flag <= 1'b0;
         rx_buffers_full_flag <= 1'b0;
         tx_end_flag <= 1'b0;
         tx_buffers_empty_flag <= 1'b0;
      end else begin
         rx_end_flag <= ~rx_cnt_nz;
         rx_buffers_full_flag <= ~rx_cnt_nz &
                                 (nxt_cnt_q[rxi] == `PDMA_RST_CNT);
         tx_end_flag <= ~tx_cnt_nz;
         tx_buffers_empty_flag <= ~tx_cnt_nz &
                                  (nxt_cnt_q[txi] == `PDMA_RST_CNT);
      end
   end

endmodule // pdma_channel

// ==== hdl/pdma_regs.vh ====
// How it works
// - Transmit count bits 15:0; zero stops
// - Nonzero count moves data only when enabled
// - Half duplex shares current and next pointers
// - Half duplex shares current and next counts
// - Receive next pointer holds following buffer address
// - Receive next count holds following buffer size
// - Transmit next pointer holds following buffer address
// - Transmit next count holds following buffer size
// - Control bit 0 enables receive unless bit 1
// - Control bit 1 disables receive requests
// - Control bit 8 enables transmit requests
// - Control bit 9 disables transmit requests
// - Half duplex: receive enable disables transmit
// - Half duplex: transmit enable needs no receive enable
// - Half duplex: receive disable also disables transmit
// - Half duplex: transmit disable also disables receive
// - Status bit 0 shows receive enable
// - Status bit 8 shows transmit enable
// - Count zero: reload from nonzero next, else stop
// - Pointer advances by 1, 2 or 4
// - Transmit end and buffers empty flags from counts
// - Receive end and buffers full flags from counts
`ifndef PDMA_REGS_VH
`define PDMA_REGS_VH

`define PDMA_A_RX_CUR_ADDR 12'h100
`define PDMA_A_RX_CUR_CNT 12'h104
`define PDMA_A_TX_CUR_ADDR 12'h108
`define PDMA_A_TX_CUR_CNT 12'h10C
`define PDMA_A_RX_NXT_ADDR 12'h110
`define PDMA_A_RX_NXT_CNT 12'h114
`define PDMA_A_TX_NXT_ADDR 12'h118
`define PDMA_A_TX_NXT_CNT 12'h11C
`define PDMA_A_CTRL 12'h120
`define PDMA_A_STAT 12'h124

`define PDMA_CNT_W 16
`define PDMA_RX_EN_BIT 0
`define PDMA_RX_DIS_BIT 1
`define PDMA_TX_EN_BIT 8
`define PDMA_TX_DIS_BIT 9

`define PDMA_SZ_BYTE 2'h0
`define PDMA_SZ_HALF 2'h1
`define PDMA_INC_BYTE 32'h0000_0001
`define PDMA_INC_HALF 32'h0000_0002
`define PDMA_INC_WORD 32'h0000_0004

`define PDMA_RST_ADDR 32'h0000_0000
`define PDMA_RST_CNT 16'h0000

`endif

// ==== dv/pdma_checker.sv ====
module pdma_checker (
   // Clock and reset
   input logic clk_sys,
   input logic rstn,
   // Register bus
   input logic hsel,
   input logic [1:0] htrans,
   input logic hwrite,
   input logic hready,
   input logic hreadyout,
   input logic hresp,
   // Peripheral side
   input logic rx_take,
   input logic [31:0] rx_data,
   input logic tx_load,
   input logic [31:0] tx_data,
   input logic rx_end_flag,
   input logic rx_buffers_full_flag,
   input logic tx_end_flag,
   input logic tx_buffers_empty_flag,
   // Memory master
   input logic mem_req,
   input logic mem_we,
   input logic [31:0] mem_addr,
   input logic [31:0] mem_wdata,
   input logic mem_ack,
   input logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rstn);
   wire go = hsel & htrans[1] & hready;

   okay_resp_a: assert property (hresp == 1'h0)
      else $error("bus response not OKAY");
   read_wait_a: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read data phase not one wait state");
   write_nowait_a: assert property (go && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   req_hold_a: assert property (mem_req && !mem_ack |=> mem_req &&
      $stable(mem_addr) && $stable(mem_we)) else $error("memory request moved");
   req_drop_a: assert property (mem_req && mem_ack |=> !mem_req)
      else $error("memory request held after ack");
   tx_deliver_a: assert property (mem_req && mem_ack && !mem_we |=>
      tx_load && tx_data == $past(mem_rdata)) else $error("tx datum lost");
   rx_store_a: assert property (rx_take |=> mem_req && mem_we &&
      mem_wdata == $past(rx_data)) else $error("rx datum not written");
   load_pulse_a: assert property (tx_load |=> !tx_load)
      else $error("tx load longer than one cycle");
   tx_flags_a: assert property (tx_buffers_empty_flag |-> tx_end_flag)
      else $error("tx empty without tx end");
   rx_flags_a: assert property (rx_buffers_full_flag |-> rx_end_flag)
      else $error("rx full without rx end");

   cover property (tx_load);
   cover property (rx_take);
   cover property (go && !hwrite ##2 hreadyout);
endmodule // pdma_checker

// ==== dv/pdma_far.sv ====
module pdma_far (
   // Clock and reset
   input logic clk_sys,
   input logic rstn,
   // Scenario controls
   input logic rx_on,
   input logic tx_on,
   input logic slow,
   // Peripheral side
   input logic rx_take,
   output logic rx_ready,
   output logic [31:0] rx_data,
   input logic tx_load,
   output logic tx_ready,
   // Memory side
   input logic mem_req,
   input logic [31:0] mem_addr,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] wait_q, gap_q;
   logic [31:0] rx_q;
   // Idle data line shows the inverse, never a stale datum
   assign rx_ready = rx_on;
   assign rx_data = rx_on ? rx_q : ~rx_q;
   assign tx_ready = tx_on && gap_q == 2'h0;
   always @(posedge clk_sys) begin
      if (!rstn) begin
         wait_q <= 2'h0;
         gap_q <= 2'h0;
         mem_ack <= 1'h0;
         mem_rdata <= 32'h0;
         rx_q <= 32'hC0DE_0000;
      end else begin
         gap_q <= tx_load ? 2'h3 : gap_q - {1'h0, gap_q != 2'h0};
         mem_ack <= mem_req && !mem_ack && wait_q == (slow ? 2'h2 : 2'h0);
         wait_q <= (mem_req && !mem_ack) ? wait_q + 2'h1 : 2'h0;
         mem_rdata <= (mem_req && !mem_ack) ? mem_addr + 32'h1000 : ~mem_rdata;
         if (rx_take)
            rx_q <= rx_q + 32'h1;
      end
   end
endmodule // pdma_far

// ==== dv/tb_top.sv ====
`include "pdma_regs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_sys = 0, rstn = 0, hsel = 0, hwrite = 0, half_duplex = 0;
   logic rx_on = 0, tx_on = 0, slow = 0;
   logic [1:0] htrans = 0, xfer_size = 0;
   logic [31:0] haddr = 0, hwdata = 0, rd;
   wire hreadyout, hresp, rx_take, tx_load, rx_ready, tx_ready;
   wire mem_req, mem_we, mem_ack, rx_end_flag, rx_buffers_full_flag;
   wire tx_end_flag, tx_buffers_empty_flag;
   wire [31:0] hrdata, rx_data, tx_data, mem_addr, mem_wdata, mem_rdata;
   wire [1:0] mem_size;
   int err_total = 0, n_tests = 0, i;
   logic [31:0] txq[$];
   logic [11:0] cw[14] = '{12'h202, 12'h003, 12'h001, 12'h100, 12'h000,
      12'h002, 12'h200, 12'h001, 12'h100, 12'h001, 12'h100, 12'h200,
      12'h100, 12'h002};
   logic [11:0] se[14] = '{12'h000, 12'h000, 12'h001, 12'h101, 12'h101,
      12'h100, 12'h000, 12'h001, 12'h101, 12'h001, 12'h101, 12'h000,
      12'h100, 12'h000};

   always #12.5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (tx_load === 1'h1) txq.push_back(tx_data);

   pdma_channel pdma_channel_i (.*, .hready(hreadyout), .hsize(3'h2));
   pdma_far pdma_far_i (.*);

   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         $display("FAIL %0t got %h exp %h", $time, got, exp);
         err_total++;
      end
   endtask

   // Waits for hready (0), tx empty (1) or rx full (2) sampled at a falling edge
   task automatic hold(input int s, input int lim);
      int k;
      logic [2:0] v;
      k = 0;
      do begin
         @(negedge clk_sys);
         k++;
         v = {rx_buffers_full_flag, tx_buffers_empty_flag, hreadyout};
      end while (v[s] !== 1'h1 && k < lim);
      if (v[s] !== 1'h1) begin
         err_total++;
         wrap_up;
      end
      rd = hrdata;
      @(posedge clk_sys);
   endtask

   task automatic bus(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      hsel <= 1'h1;
      haddr <= {20'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      hold(0, 40);
      htrans <= 2'h0;
      hwdata <= d;
      hold(0, 40);
   endtask

   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      bus(1'h0, a, 32'h0);
      chk(rd, exp);
   endtask

   initial begin
      repeat (6) @(posedge clk_sys);
      rstn <= 1'h1;
      repeat (2) @(posedge clk_sys);
      rdc(`PDMA_A_STAT, 32'h0);
      rdc(`PDMA_A_TX_CUR_CNT, 32'h0);
      rdc(12'h12C, 32'h0);
      bus(1'h1, `PDMA_A_STAT, 32'hFFFF_FFFF);
      rdc(`PDMA_A_STAT, 32'h0);
      $display("Test reset done");
      bus(1'h1, `PDMA_A_RX_CUR_CNT, 32'h1);
      bus(1'h1, `PDMA_A_TX_CUR_CNT, 32'h1);
      for (i = 0; i < 2; i++) begin
         bus(1'h1, 12'h110 + 12'(8 * i), 32'h1234_5678);
         bus(1'h1, 12'h114 + 12'(8 * i), 32'hDEAD_BEEF);
         rdc(12'h110 + 12'(8 * i), 32'h1234_5678);
         rdc(12'h114 + 12'(8 * i), 32'h0000_BEEF);
      end
      $display("Test next registers done");
      bus(1'h1, `PDMA_A_TX_CUR_ADDR, 32'h2000);
      bus(1'h1, `PDMA_A_TX_NXT_CNT, 32'h0);
      bus(1'h1, `PDMA_A_TX_CUR_CNT, 32'h0001_0002);
      xfer_size <= 2'h2;
      tx_on <= 1'h1;
      slow <= 1'h1;
      rdc(`PDMA_A_TX_CUR_CNT, 32'h2);
      chk(32'(txq.size()), 32'h0);
      bus(1'h1, `PDMA_A_CTRL, 32'h100);
      hold(1, 300);
      chk(32'(txq.size()), 32'h2);
      chk(txq[0], 32'h3000);
      chk(txq[1], 32'h3004);
      rdc(`PDMA_A_TX_CUR_ADDR, 32'h2008);
      chk({31'h0, tx_end_flag}, 32'h1);
      rdc(`PDMA_A_STAT, 32'h100);
      chk(32'(txq.size()), 32'h2);
      $display("Test transmit done");
      xfer_size <= 2'h0;
      slow <= 1'h0;
      bus(1'h1, `PDMA_A_RX_CUR_ADDR, 32'h200);
      bus(1'h1, `PDMA_A_RX_NXT_ADDR, 32'h300);
      bus(1'h1, `PDMA_A_RX_NXT_CNT, 32'h1);
      rx_on <= 1'h1;
      bus(1'h1, `PDMA_A_CTRL, 32'h001);
      hold(2, 300);
      rdc(`PDMA_A_RX_CUR_ADDR, 32'h301);
      rdc(`PDMA_A_RX_NXT_CNT, 32'h0);
      chk({31'h0, rx_end_flag}, 32'h1);
      rx_on <= 1'h0;
      tx_on <= 1'h0;
      $display("Test receive done");
      for (i = 0; i < 14; i++) begin
         half_duplex <= (i > 6);
         bus(1'h1, `PDMA_A_CTRL, {20'h0, cw[i]});
         rdc(`PDMA_A_STAT, {20'h0, se[i]});
      end
      $display("Test control done");
      bus(1'h1, `PDMA_A_RX_CUR_ADDR, 32'h4400);
      rdc(`PDMA_A_TX_CUR_ADDR, 32'h4400);
      bus(1'h1, `PDMA_A_TX_CUR_CNT, 32'h5);
      rdc(`PDMA_A_RX_CUR_CNT, 32'h5);
      bus(1'h1, `PDMA_A_RX_NXT_ADDR, 32'h4800);
      rdc(`PDMA_A_TX_NXT_ADDR, 32'h4800);
      bus(1'h1, `PDMA_A_RX_NXT_CNT, 32'h7);
      rdc(`PDMA_A_TX_NXT_CNT, 32'h7);
      $display("Test half duplex done");
      wrap_up;
   end
endmodule // tb_top

bind pdma_channel pdma_checker pdma_checker_i (.*);
